// >>> hdl/osc_select_pkg.sv
/*
 * Shared constants, codes and carrier types for the system clock
 * source selector: clock rate, derived cycle counts, source and
 * external-mode encodings, register map and interrupt bit layout.
 * Assumes a single 50 MHz block clock that stands for the internal
 * fast source output.
 */
`default_nettype none

package osc_select_pkg;

	// ------------------------------------------------------------
	// clock and derived timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int MID_FAST_HZ = 500_000;
	localparam int MID_SLOW_HZ = 32_000;
	localparam int SLOW_HZ = 31_000;
	localparam int MID_FAST_DIV = CLK_HZ / MID_FAST_HZ;
	localparam int MID_SLOW_DIV = CLK_HZ / MID_SLOW_HZ;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	localparam int STARTUP_EDGES = 1024;
	localparam int HALT_TIME_NS = 2000;
	localparam int FAIL_TIME_NS = 64000;
	localparam int HALT_CYCLES =
		(HALT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAIL_CYCLES =
		(FAIL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_W = 12;
	localparam int START_W = 11;
	localparam int SYS_CNT_W = 9;

	// ------------------------------------------------------------
	// source and mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_FAST_32M = 3'h0;
	localparam logic [2:0] SRC_FAST_PLL2 = 3'h1;
	localparam logic [2:0] SRC_EXT_PLL4 = 3'h2;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_SLOW = 3'h5;
	localparam logic [2:0] SRC_FAST_1M = 3'h6;
	localparam logic [2:0] SRC_EXT = 3'h7;
	localparam logic [2:0] SRC_FALLBACK = SRC_FAST_1M;
	localparam logic [2:0] EXT_LOW_GAIN = 3'h0;
	localparam logic [2:0] EXT_MED_GAIN = 3'h1;
	localparam logic [2:0] EXT_HIGH_GAIN = 3'h2;
	localparam logic [2:0] EXT_CLK_LOW = 3'h5;
	localparam logic [2:0] EXT_CLK_MED = 3'h6;
	localparam logic [2:0] EXT_CLK_HIGH = 3'h7;
	localparam logic [1:0] GAIN_NONE = 2'h0;
	localparam logic [1:0] GAIN_LOW = 2'h1;
	localparam logic [1:0] GAIN_MED = 2'h2;
	localparam logic [1:0] GAIN_HIGH = 2'h3;
	localparam logic [3:0] DIV_MAX_CODE = 4'h9;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_DIV = 4'h2;
	localparam logic [3:0] ADDR_MODE = 4'h3;
	localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
	localparam logic [3:0] ADDR_INT_ENABLE = 4'h5;
	localparam logic [3:0] ADDR_INT_CLEAR = 4'h6;
	localparam int IRQ_SWITCH = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_STARTUP = 2;
	localparam int IRQ_W = 3;

	// nonvolatile configuration fields
	typedef struct packed {
		logic [2:0] reset_osc_select;
		logic [2:0] external_mode_select;
		logic clock_output_enable;
	} cfg_t;

endpackage

`default_nettype wire

// >>> hdl/pin_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes each bit is a level that stays for several clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	// ------------------------------------------------------------
	// two stages, first read only by second
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= '0;
			q_out <= '0;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule // pin_sync

`default_nettype wire

// >>> hdl/tick_divider.sv
/*
 * Fixed ratio divider giving a one-cycle tick every DIV clocks.
 * Assumes DIV of at least two.
 */
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
	parameter int DIV = 100
) (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic tick_out
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_q;

	// ------------------------------------------------------------
	// free-running count and tick
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
			tick_out <= (cnt_q == LAST);
		end
	end

	property p_tick_single;
		@(posedge clk_in) disable iff (rst_in)
		tick_out |=> !tick_out;
	endproperty
	a_tick_single: assert property (p_tick_single) // [R11]
		else $error("divider tick longer than one cycle");
endmodule // tick_divider

`default_nettype wire

// >>> hdl/osc_source_select.sv
/*
 * System clock source selector: reset choice from configuration,
 * run-time switch requests with divider, crystal start-up count,
 * external clock halt and fail fallback, pin function and gain.
 * Assumes CONFIG_IN is stable from reset release, WAKE_IN is a
 * one-cycle pulse from same-clock sleep logic, and the external
 * pin toggles well below half the block clock rate.
 */
// Chosen here: the placing of the registers and strobed register access.
// Contract
// R1 - after any reset the configured reset selection picks the source
// R2 - reset choices include slow internal, fast at 1 MHz, fast at 32 MHz
// R3 - external mode field plus reset selection give six external modes
// R4 - external clock reachable by reset selection or software request
// R5 - lost external clock in any external mode falls back to internal
// R6 - crystal modes wait 1024 pin cycles after power-on or wake
// R7 - logic-level clock modes start with no start-up delay
// R8 - stopped external clock halts the block, state kept, then resumes
// R9 - in clock modes second pin is general I/O or clock output
// R10 - crystal modes choose low, medium or high amplifier gain
// R11 - fast internal derives 500 kHz and 32 kHz; slow runs 31 kHz
// R12 - code 010 at reset or by request enables the 4x multiplier
// R13 - keep current source until new one is ready, then set flag
// R14 - selected source divided by software ratio 1:1 to 1:512
// R15 - start-up count restarts on reset or wake, holds clock gated
`timescale 1ns/1ps
`default_nettype none

module osc_source_select (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic WAKE_IN,
	input wire osc_select_pkg::cfg_t CONFIG_IN,
	input wire logic OSC_INPUT_PIN_IN,
	input wire logic FAST_READY_IN,
	input wire logic SLOW_READY_IN,
	input wire logic GPIO_DATA_IN,
	input wire logic GPIO_OE_IN,
	input wire logic [osc_select_pkg::ADDR_W-1:0] ADDR_IN,
	input wire logic [osc_select_pkg::DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [osc_select_pkg::DATA_W-1:0] RDATA_OUT,
	output logic IRQ_OUT,
	output logic [2:0] CUR_SOURCE_OUT,
	output logic SYS_RUN_OUT,
	output logic SYS_TICK_OUT,
	output logic MID_FAST_TICK_OUT,
	output logic MID_SLOW_TICK_OUT,
	output logic SLOW_TICK_OUT,
	output logic [1:0] GAIN_OUT,
	output logic PLL4_EN_OUT,
	output logic OSC_OUTPUT_PIN_OUT,
	output logic OSC_OUTPUT_PIN_OE_OUT
);
	import osc_select_pkg::*;

	localparam logic [START_W-1:0] START_LAST = START_W'(STARTUP_EDGES - 1);
	localparam logic [IDLE_W-1:0] IDLE_HALT = IDLE_W'(HALT_CYCLES);
	localparam logic [IDLE_W-1:0] IDLE_FAIL = IDLE_W'(FAIL_CYCLES);

	typedef enum logic {ST_IDLE, ST_WAIT} sw_state_t;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	function automatic logic is_ext_src(input logic [2:0] s);
		is_ext_src = (s == SRC_EXT) || (s == SRC_EXT_PLL4);
	endfunction

	function automatic logic is_crystal(input logic [2:0] m);
		is_crystal = (m == EXT_LOW_GAIN) || (m == EXT_MED_GAIN) ||
			(m == EXT_HIGH_GAIN);
	endfunction

	function automatic logic is_ec(input logic [2:0] m);
		is_ec = (m == EXT_CLK_LOW) || (m == EXT_CLK_MED) ||
			(m == EXT_CLK_HIGH);
	endfunction

	function automatic logic [SYS_CNT_W-1:0] div_mask(input logic [3:0] c);
		div_mask = SYS_CNT_W'((10'h001 << c) - 10'h001);
	endfunction

	function automatic logic [3:0] div_clamp(input logic [3:0] c);
		div_clamp = (c > DIV_MAX_CODE) ? DIV_MAX_CODE : c;
	endfunction

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [2:0] async_s;
	logic pin_s, fast_rdy_s, slow_rdy_s, pin_prev_q, pin_rise;
	logic slow_tick;
	logic loaded_q, load_now;
	cfg_t cfg_q;
	logic [2:0] cur_src_q, new_src_q;
	logic [3:0] cur_div_q, new_div_q;
	sw_state_t sw_q;
	logic ready_flag_q;
	logic [START_W-1:0] start_cnt_q;
	logic start_done_q;
	logic [IDLE_W-1:0] idle_q;
	logic ext_active, ext_ok, fail_now, fail_q;
	logic new_ready, switch_done, ctrl_wr;
	logic src_edge, run;
	logic [SYS_CNT_W-1:0] sys_cnt_q;
	logic div_load_q;
	logic clkout_q;
	logic [IRQ_W-1:0] int_stat_q, int_en_q, int_evt, int_stat_d;

	// ------------------------------------------------------------
	// pin and ready synchronisers, derived internal clocks
	// ------------------------------------------------------------
	pin_sync #(.W(3)) u_sync (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.d_in({OSC_INPUT_PIN_IN, FAST_READY_IN, SLOW_READY_IN}),
		.q_out(async_s)
	);
	assign pin_s = async_s[2];
	assign fast_rdy_s = async_s[1];
	assign slow_rdy_s = async_s[0];

	// mid clocks derived from the fast internal source [R11]
	tick_divider #(.DIV(MID_FAST_DIV)) u_mid_fast (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.tick_out(MID_FAST_TICK_OUT)
	);
	tick_divider #(.DIV(MID_SLOW_DIV)) u_mid_slow (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.tick_out(MID_SLOW_TICK_OUT)
	);
	tick_divider #(.DIV(SLOW_DIV)) u_slow (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.tick_out(slow_tick)
	);
	assign SLOW_TICK_OUT = slow_tick;

	// edge detect on synchronised pin
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
		end
	end
	assign pin_rise = pin_s && !pin_prev_q;

	// ------------------------------------------------------------
	// configuration capture after reset release
	// ------------------------------------------------------------
	assign load_now = !loaded_q;

	// fields taken on first edge after release [R1]
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			loaded_q <= 1'b0;
			cfg_q <= '0;
		end else if (load_now) begin
			loaded_q <= 1'b1;
			cfg_q <= CONFIG_IN; // [R1] [R3]
		end
	end

	// ------------------------------------------------------------
	// crystal start-up count
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			start_cnt_q <= '0;
			start_done_q <= 1'b0;
		end else if (load_now || WAKE_IN) begin
			start_cnt_q <= '0; // [R15]
			start_done_q <= load_now ?
				!is_crystal(CONFIG_IN.external_mode_select) :
				!is_crystal(cfg_q.external_mode_select); // [R7]
		end else if (is_crystal(cfg_q.external_mode_select) &&
			!start_done_q && pin_rise) begin
			start_cnt_q <= start_cnt_q + 1'b1; // [R6]
			start_done_q <= (start_cnt_q == START_LAST); // [R6]
		end
	end

	// ------------------------------------------------------------
	// activity monitor: halt and fail detection
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			idle_q <= '0;
		end else if (load_now || pin_rise) begin
			idle_q <= '0;
		end else if (idle_q != IDLE_FAIL) begin
			idle_q <= idle_q + 1'b1;
		end
	end
	assign ext_active = (idle_q < IDLE_HALT);
	assign ext_ok = start_done_q && ext_active &&
		(is_crystal(cfg_q.external_mode_select) ||
		is_ec(cfg_q.external_mode_select));
	assign fail_now = loaded_q && is_ext_src(cur_src_q) &&
		(idle_q == IDLE_FAIL); // [R5]

	// ------------------------------------------------------------
	// source request and switch sequencing
	// ------------------------------------------------------------
	assign ctrl_wr = WR_IN && (ADDR_IN == ADDR_CTRL);

	always_comb begin
		if (new_src_q == cur_src_q) begin
			new_ready = 1'b1;
		end else if (is_ext_src(new_src_q)) begin
			new_ready = ext_ok;
		end else if (new_src_q == SRC_SLOW) begin
			new_ready = slow_rdy_s;
		end else if (new_src_q == SRC_SECONDARY) begin
			new_ready = 1'b0;
		end else begin
			new_ready = fast_rdy_s;
		end
	end
	assign switch_done = (sw_q == ST_WAIT) && new_ready && !fail_now;

	// request fields and wait state
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sw_q <= ST_IDLE;
			new_src_q <= SRC_FAST_32M;
			new_div_q <= '0;
		end else if (load_now) begin
			new_src_q <= CONFIG_IN.reset_osc_select;
			new_div_q <= '0;
		end else if (ctrl_wr) begin
			new_src_q <= WDATA_IN[2:0]; // [R4] [R12]
			new_div_q <= div_clamp(WDATA_IN[7:4]); // [R14]
			sw_q <= ST_WAIT;
		end else begin
			case (sw_q)
				ST_IDLE: sw_q <= ST_IDLE;
				ST_WAIT: begin
					if (switch_done) begin
						sw_q <= ST_IDLE; // [R13]
					end
				end
				default: sw_q <= ST_IDLE;
			endcase
		end
	end

	// current source: reset choice, fallback, completed switch
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cur_src_q <= SRC_FAST_32M;
			cur_div_q <= '0;
			fail_q <= 1'b0;
		end else if (load_now) begin
			cur_src_q <= CONFIG_IN.reset_osc_select; // [R1] [R2]
			cur_div_q <= '0;
			fail_q <= 1'b0;
		end else if (fail_now) begin
			cur_src_q <= SRC_FALLBACK; // [R5]
			fail_q <= 1'b1;
		end else if (switch_done) begin
			cur_src_q <= new_src_q; // [R13]
			cur_div_q <= new_div_q;
			fail_q <= 1'b0;
		end
	end

	// ready flag: completion wins over clearing write
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ready_flag_q <= 1'b0;
		end else if (switch_done) begin
			ready_flag_q <= 1'b1; // [R13]
		end else if (ctrl_wr) begin
			ready_flag_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// system divider and run gate
	// ------------------------------------------------------------
	always_comb begin
		if (is_ext_src(cur_src_q)) begin
			src_edge = pin_rise;
		end else if (cur_src_q == SRC_SLOW) begin
			src_edge = slow_tick;
		end else begin
			src_edge = 1'b1;
		end
	end
	// halt with state kept while external clock is absent
	assign run = loaded_q &&
		(!is_ext_src(cur_src_q) || (start_done_q && ext_active)); // [R8]

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sys_cnt_q <= '0;
			div_load_q <= 1'b0;
			SYS_TICK_OUT <= 1'b0;
			SYS_RUN_OUT <= 1'b0;
		end else begin
			SYS_RUN_OUT <= run; // [R15]
			SYS_TICK_OUT <= 1'b0;
			div_load_q <= switch_done;
			// restart the count once a new ratio is in force
			if (div_load_q) begin
				sys_cnt_q <= '0; // [R14]
			end else if (run && src_edge) begin
				if (sys_cnt_q >= div_mask(cur_div_q)) begin
					sys_cnt_q <= '0; // [R14]
					SYS_TICK_OUT <= 1'b1;
				end else begin
					sys_cnt_q <= sys_cnt_q + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pin function, gain and multiplier outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			clkout_q <= 1'b0;
			OSC_OUTPUT_PIN_OUT <= 1'b0;
			OSC_OUTPUT_PIN_OE_OUT <= 1'b0;
			GAIN_OUT <= GAIN_NONE;
			PLL4_EN_OUT <= 1'b0;
			CUR_SOURCE_OUT <= SRC_FAST_32M;
		end else begin
			CUR_SOURCE_OUT <= cur_src_q;
			PLL4_EN_OUT <= (cur_src_q == SRC_EXT_PLL4); // [R12]
			if (SYS_TICK_OUT) begin
				clkout_q <= !clkout_q;
			end
			if (is_crystal(cfg_q.external_mode_select)) begin
				OSC_OUTPUT_PIN_OUT <= 1'b0;
				OSC_OUTPUT_PIN_OE_OUT <= 1'b0;
			end else if (cfg_q.clock_output_enable) begin
				OSC_OUTPUT_PIN_OUT <= clkout_q; // [R9]
				OSC_OUTPUT_PIN_OE_OUT <= 1'b1;
			end else begin
				OSC_OUTPUT_PIN_OUT <= GPIO_DATA_IN; // [R9]
				OSC_OUTPUT_PIN_OE_OUT <= GPIO_OE_IN;
			end
			case (cfg_q.external_mode_select)
				EXT_LOW_GAIN: GAIN_OUT <= GAIN_LOW; // [R10]
				EXT_MED_GAIN: GAIN_OUT <= GAIN_MED;
				EXT_HIGH_GAIN: GAIN_OUT <= GAIN_HIGH;
				default: GAIN_OUT <= GAIN_NONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupt status, enable and clear
	// ------------------------------------------------------------
	always_comb begin
		int_evt = '0;
		int_evt[IRQ_SWITCH] = switch_done;
		int_evt[IRQ_FAIL] = fail_now;
		int_evt[IRQ_STARTUP] = !load_now && !WAKE_IN && pin_rise &&
			!start_done_q && is_crystal(cfg_q.external_mode_select) &&
			(start_cnt_q == START_LAST);
		int_stat_d = int_stat_q | int_evt;
		if (WR_IN && (ADDR_IN == ADDR_INT_CLEAR)) begin
			int_stat_d = (int_stat_q & ~WDATA_IN[IRQ_W-1:0]) | int_evt;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			int_stat_q <= '0;
			int_en_q <= '0;
			IRQ_OUT <= 1'b0;
		end else begin
			int_stat_q <= int_stat_d;
			if (WR_IN && (ADDR_IN == ADDR_INT_ENABLE)) begin
				int_en_q <= WDATA_IN[IRQ_W-1:0];
			end
			IRQ_OUT <= |(int_stat_d & int_en_q);
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RDATA_OUT <= '0;
		end else if (!RD_IN) begin
			RDATA_OUT <= '0;
		end else if (ADDR_IN == ADDR_CTRL) begin
			RDATA_OUT <= {new_div_q, 1'b0, new_src_q};
		end else if (ADDR_IN == ADDR_STATUS) begin
			RDATA_OUT <= {ext_active, sw_q == ST_WAIT, fail_q,
				start_done_q, ready_flag_q, cur_src_q};
		end else if (ADDR_IN == ADDR_DIV) begin
			RDATA_OUT <= {4'h0, cur_div_q};
		end else if (ADDR_IN == ADDR_MODE) begin
			RDATA_OUT <= {1'b0, cfg_q};
		end else if (ADDR_IN == ADDR_INT_STATUS) begin
			RDATA_OUT <= {5'h00, int_stat_q};
		end else if (ADDR_IN == ADDR_INT_ENABLE) begin
			RDATA_OUT <= {5'h00, int_en_q};
		end else begin
			RDATA_OUT <= '0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_reset_source;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		load_now |=> (cur_src_q == $past(CONFIG_IN.reset_osc_select))
			##1 (CUR_SOURCE_OUT == $past(cur_src_q));
	endproperty
	a_reset_source: assert property (p_reset_source) // [R1]
		else $error("reset source not taken from configuration");

	property p_ec_no_delay;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(load_now && is_ec(CONFIG_IN.external_mode_select)) |=>
			start_done_q;
	endproperty
	a_ec_no_delay: assert property (p_ec_no_delay) // [R7]
		else $error("clock mode start-up not immediate");

	property p_startup_count;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		($rose(start_done_q) && !$past(load_now) && !$past(WAKE_IN)) |->
			$past(start_cnt_q) == START_LAST;
	endproperty
	a_startup_count: assert property (p_startup_count) // [R6]
		else $error("start-up ended at wrong edge count");

	property p_startup_gate;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(is_ext_src(cur_src_q) && !start_done_q) |=> !SYS_RUN_OUT;
	endproperty
	a_startup_gate: assert property (p_startup_gate) // [R15]
		else $error("system clock ran before start-up count done");

	property p_fallback;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		fail_now |=> (cur_src_q == SRC_FALLBACK) && fail_q &&
			int_stat_q[IRQ_FAIL];
	endproperty
	a_fallback: assert property (p_fallback) // [R5]
		else $error("no fallback after external clock loss");

	property p_halt;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(is_ext_src(cur_src_q) && !ext_active) |=>
			$stable(sys_cnt_q) && !SYS_TICK_OUT;
	endproperty
	a_halt: assert property (p_halt) // [R8]
		else $error("divider moved while external clock absent");

	property p_clkout_pin;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(loaded_q && is_ec(cfg_q.external_mode_select) &&
			cfg_q.clock_output_enable) |=> OSC_OUTPUT_PIN_OE_OUT;
	endproperty
	a_clkout_pin: assert property (p_clkout_pin) // [R9]
		else $error("clock output not driven");

	property p_gain;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(cfg_q.external_mode_select == EXT_HIGH_GAIN) |=>
			GAIN_OUT == GAIN_HIGH;
	endproperty
	a_gain: assert property (p_gain) // [R10]
		else $error("high gain mode without high gain");

	property p_pll4;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(cur_src_q == SRC_EXT_PLL4) |=> PLL4_EN_OUT;
	endproperty
	a_pll4: assert property (p_pll4) // [R12]
		else $error("multiplier not enabled for code 010");

	property p_hold_old;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(sw_q == ST_WAIT && !new_ready && !fail_now) |=>
			$stable(cur_src_q) && $stable(cur_div_q);
	endproperty
	a_hold_old: assert property (p_hold_old) // [R13]
		else $error("source changed before new source ready");

	property p_ready_flag;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		switch_done |=> ready_flag_q && (cur_src_q == $past(new_src_q));
	endproperty
	a_ready_flag: assert property (p_ready_flag) // [R13]
		else $error("ready flag or source missing after switch");

	property p_div_range;
		@(posedge CLOCK_IN) disable iff (RST_IN)
		(cur_div_q <= DIV_MAX_CODE) &&
			(sys_cnt_q <= div_mask(cur_div_q) || $changed(cur_div_q));
	endproperty
	a_div_range: assert property (p_div_range) // [R14]
		else $error("divider beyond 1:512 or count past ratio");

	c_switch: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
		switch_done && is_ext_src(new_src_q));
	c_fail: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
		fail_now);
	c_startup: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$rose(start_done_q) && !$past(load_now));
	c_irq: cover property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$rose(IRQ_OUT));
endmodule // osc_source_select

`default_nettype wire

// >>> sim/ext_clock_src.sv
/* stand-in for an external clock or crystal on the oscillator pin
 assumes the bench clock; HALF is the half period in block clocks */
`timescale 1ns/1ps
`default_nettype none
module ext_clock_src #(
	parameter int HALF = 4
) (
	input wire logic clk_in,
	input wire logic run_in,
	output logic pin_out
);
	int cnt = 0;
	initial pin_out = 1'b0;
	// toggles each half period, freezes at its level when stopped
	always @(posedge clk_in) begin
		if (run_in && cnt >= HALF - 1) begin
			cnt <= 0;
			pin_out <= ~pin_out;
		end else if (run_in) begin
			cnt <= cnt + 1;
		end
	end
endmodule // ext_clock_src
`default_nettype wire

// >>> sim/osc_source_select_tb.sv
/* self-checking bench for the clock source selector
 assumes the package and the pin stand-in model */
`timescale 1ns/1ps
`default_nettype none
module osc_source_select_tb;
	import osc_select_pkg::*;
	logic c = 0, rst = 1, wk = 0, run = 1, sr = 0, wr = 0, rd = 0;
	logic irq, srun, pll, oe, pin, mft, st, po, pq, mst, slt;
	logic [3:0] ad = 0;
	logic [7:0] wd = 0, rdat, d;
	logic [2:0] cur;
	logic [1:0] gain;
	logic [2:0] src [3] = '{SRC_SLOW, SRC_FAST_1M, SRC_FAST_32M};
	cfg_t cfg = '0;
	int error_cnt = 0, cmp_count = 0, i, r, tk, tg;
	int ms_n = 0, ms_gap = 0, sl_n = 0, sl_gap = 0;
	always #10 c = ~c;
	ext_clock_src u_ext_clock_src (.clk_in(c), .run_in(run), .pin_out(pin));
	osc_source_select u_osc_source_select (.CLOCK_IN(c), .RST_IN(rst),
		.WAKE_IN(wk), .CONFIG_IN(cfg), .OSC_INPUT_PIN_IN(pin),
		.FAST_READY_IN(1'b1), .SLOW_READY_IN(sr), .GPIO_DATA_IN(1'b0),
		.GPIO_OE_IN(1'b0), .ADDR_IN(ad), .WDATA_IN(wd), .WR_IN(wr),
		.RD_IN(rd), .RDATA_OUT(rdat), .IRQ_OUT(irq), .CUR_SOURCE_OUT(cur),
		.SYS_RUN_OUT(srun), .SYS_TICK_OUT(st), .MID_FAST_TICK_OUT(mft),
		.MID_SLOW_TICK_OUT(mst), .SLOW_TICK_OUT(slt), .GAIN_OUT(gain),
		.PLL4_EN_OUT(pll), .OSC_OUTPUT_PIN_OUT(po),
		.OSC_OUTPUT_PIN_OE_OUT(oe));
	// cycles between derived ticks
	always @(posedge c) begin
		ms_n <= mst ? 1 : ms_n + 1;
		sl_n <= slt ? 1 : sl_n + 1;
		if (mst) ms_gap <= ms_n;
		if (slt) sl_gap <= sl_n;
	end
	// compare and verdict
	task chk(input string n, input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task end_sim;
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// register bus cycles, plain waits and reset with configuration
	task bw(input logic [3:0] a, input logic [7:0] v);
		@(posedge c);
		wr <= 1'b1;
		ad <= a;
		wd <= v;
		@(posedge c);
		wr <= 1'b0;
	endtask
	task br(input logic [3:0] a);
		@(posedge c);
		rd <= 1'b1;
		ad <= a;
		@(posedge c);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge c);
		#1;
	endtask
	task rs(input logic [2:0] s, m);
		@(posedge c);
		cfg <= '{s, m, 1'b1};
		rst <= 1'b1;
		repeat (16) @(posedge c);
		rst <= 1'b0;
		cyc(3);
	endtask
	// main sequence
	initial begin
		void'($urandom(73240));
		for (i = 0; i < 3; i++) begin
			rs(src[i], EXT_CLK_HIGH);
			chk("cur", cur, src[i]);
		end
		for (i = 0; i < 3; i++) begin
			rs(SRC_EXT, EXT_LOW_GAIN + i[2:0]);
			chk("gain", gain, GAIN_LOW + i[1:0]);
		end
		br(ADDR_MODE);
		chk("mode", d, {1'b0, cfg});
		cyc(8000);
		chk("hold", srun, 0);
		for (i = 0; i < 600 && srun !== 1'b1; i++) cyc(1);
		chk("run", srun, 1);
		@(posedge c) wk <= 1'b1;
		@(posedge c) wk <= 1'b0;
		cyc(3);
		chk("wake", srun, 0);
		rs(SRC_EXT, EXT_CLK_HIGH);
		for (i = 0; i < 30 && srun !== 1'b1; i++) cyc(1);
		chk("ec", {oe, srun}, 2'h3);
		r = 0;
		repeat (1000) begin
			cyc(1);
			r += mft;
		end
		chk("mid", r, 1000 / MID_FAST_DIV);
		// halt, resume, then loss and fallback
		bw(ADDR_INT_ENABLE, 8'h03);
		run <= 1'b0;
		for (i = 0; i < 150 && srun !== 1'b0; i++) cyc(1);
		chk("halt", srun, 0);
		cyc(500);
		run <= 1'b1;
		for (i = 0; i < 40 && srun !== 1'b1; i++) cyc(1);
		chk("resume", {srun, cur}, {1'b1, SRC_EXT});
		run <= 1'b0;
		for (i = 0; i < 3400 && cur !== SRC_FALLBACK; i++) cyc(1);
		chk("fail", cur, SRC_FALLBACK);
		cyc(3);
		br(ADDR_INT_STATUS);
		chk("irq", {irq, d[1]}, 2'h3);
		bw(ADDR_INT_CLEAR, 8'h03);
		cyc(3);
		chk("clr", irq, 0);
		// software switch with random divider
		r = $urandom % 16;
		bw(ADDR_CTRL, {r[3:0], 1'b0, SRC_SLOW});
		cyc(20);
		chk("keep", cur, SRC_FALLBACK);
		sr <= 1'b1;
		for (i = 0; i < 20 && cur !== SRC_SLOW; i++) cyc(1);
		br(ADDR_STATUS);
		chk("sw", d[3:0], {1'b1, SRC_SLOW});
		br(ADDR_DIV);
		chk("div", d, (r > 9) ? 9 : r);
		run <= 1'b1;
		bw(ADDR_CTRL, {4'h0, 1'b0, SRC_EXT_PLL4});
		for (i = 0; i < 100 && cur !== SRC_EXT_PLL4; i++) cyc(1);
		cyc(1);
		chk("pll", {pll, cur}, {1'b1, SRC_EXT_PLL4});
		// fast source with random ratio: tick and clock output rates
		r = $urandom % 16;
		bw(ADDR_CTRL, {r[3:0], 1'b0, SRC_FAST_32M});
		r = (r > 9) ? 9 : r;
		cyc(10);
		br(ADDR_CTRL);
		chk("ctrl", d, {r[3:0], 1'b0, SRC_FAST_32M});
		tk = 0;
		tg = 0;
		pq = po;
		repeat (2048) begin
			cyc(1);
			tk += st;
			tg += po ^ pq;
			pq = po;
		end
		chk("tick", tk, 2048 >> r);
		chk("clkout", tg, 2048 >> r);
		chk("midslow", ms_gap, MID_SLOW_DIV);
		chk("slow", sl_gap, SLOW_DIV);
		br(4'hf);
		chk("unmap", d, 0);
		end_sim;
	end
	// watchdog
	initial begin
		#(CLK_PERIOD_NS * 40000);
		error_cnt++;
		end_sim;
	end
endmodule // osc_source_select_tb
`default_nettype wire
